// ---- design/adc_front_regs.vh ----
`ifndef ADC_FRONT_REGS_VH
`define ADC_FRONT_REGS_VH

// control register addresses
`define ADDR_POWER_CTRL     8'h00
`define ADDR_INPUT_SELECT   8'h09
`define ADDR_TRANSITION     8'h0c
`define ADDR_LINE_POWER     8'h0f
`define ADDR_MIC_GAIN       8'h12
`define ADDR_LINE_GAIN      8'h13
`define ADDR_GAIN_CTRL      8'h1a
`define ADDR_DSP_GAIN_READ  8'h1b
`define ADDR_DMIC_CTRL      8'h1e

// field positions
`define BIT_ANALOG_INPUT_EN 3
`define BIT_LEFT_PIN_SEL    4
`define BIT_LEFT_DIFF       5
`define BIT_RIGHT_PIN_SEL   6
`define BIT_RIGHT_DIFF      7
`define BIT_SLOW_TRANSITION 5
`define BIT_LINE_AMP_POWER  5
`define BIT_LEFT_ZC_EN      0
`define BIT_RIGHT_ZC_EN     1
`define BIT_LEFT_DSP_EN     2
`define BIT_RIGHT_DSP_EN    3
`define BIT_SECOND_ADC_MUTE       6
`define BIT_ADC_MUTE        7
`define BIT_DIGITAL_MIC_2_ENABLE_EN        4
`define BIT_DIGITAL_MIC_1_ENABLE_EN        7

// reset value and unavailable line gain code
`define RESET_BYTE          8'h00
`define LINE_GAIN_NA        4'h8

// source codes
`define SRC_SINGLE_A        2'h0
`define SRC_SINGLE_B        2'h1
`define SRC_DIFF            2'h2
`define SECOND_ADC_SRC_NONE       2'h0
`define SECOND_ADC_SRC_LINE       2'h1
`define SECOND_ADC_SRC_DMIC       2'h2

// timing: timeout given in ms at a kHz rate, other counts in frame-clock samples
`define ZC_TIMEOUT_MS       16
`define ZC_RATE_KHZ         48
`define ZC_TIMEOUT_SAMPLES  (`ZC_TIMEOUT_MS * `ZC_RATE_KHZ)
`define MUTE_RAMP_SAMPLES   828
`define SLOW_STEP_SAMPLES   4

// dc blocker shift: cutoff = fs / (2 pi 2^11)
`define HPF_SHIFT           11

`endif

// ---- design/adc_input_gain_mute_ctrl.v ----
// What this block does
// RL1 - analog enable routes shared pins to analog path; either dmic enable to dmic
// RL2 - left: diff 0 picks IN1/IN2 by selector; diff 1 takes pair 1
// RL3 - right: diff 0 picks IN3/IN4 by selector; diff 1 takes pair 2
// RL4 - mic gain register: left code bits 3-0, right code bits 7-4
// RL5 - codes 0-9 are 0-18 dB by 2 dB, A-F are 21-36 dB by 3
// RL6 - zero-cross enabled: new gain applied at crossing or timeout, per channel
// RL7 - timeout is 16 ms at 48 kHz after the write, then gain applied
// RL8 - zero-cross disabled: written gain applied at once
// RL9 - writing the present gain does not restart the timeout
// RL10 - host spaces mic gain writes by at least one timeout period
// RL11 - dsp gain enable: dsp sets gain, register field ignored, zero-cross still applies
// RL12 - dsp applied gains readable, left bits 3-0, right bits 7-4
// RL13 - line amp runs only while powered, feeds second adc left channel
// RL14 - line codes 0-7 are 0 to -21 dB, 8 unavailable, 9-F +3 to +21
// RL15 - digital_mic_2_enable on: second adc both channels from digital_mic_2_enable pin; off: line left only
// RL16 - dc-blocking high-pass: 3.73 Hz at 48k, 3.43 at 44.1k, 0.62 at 8k
// RL17 - soft mute ramps to full attenuation; clearing ramps back
// RL18 - mute cancelled mid-ramp returns at the same step rate
// RL19 - full ramp is 828 frame cycles, four times longer when slow
// RL20 - soft mute acts only while operating; power-down pin resets attenuation
// RL21 - host mutes, switches input, waits about 200 ms, then unmutes
// RL22 - slow transition bit: step every sample, or every four samples
// RL23 - ramp and timeout counters advance once per frame-clock sample
`timescale 1ns/1ns
`include "adc_front_regs.vh"

module adc_input_gain_mute_ctrl (
    input wire CLK,
    input wire RST_N,
    input wire REG_WRITE,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    input wire FRAME_CLOCK,
    input wire POWER_DOWN_PIN_N,
    input wire ZERO_CROSS_LEFT,
    input wire ZERO_CROSS_RIGHT,
    input wire [3:0] DSP_GAIN_LEFT,
    input wire [3:0] DSP_GAIN_RIGHT,
    input wire [23:0] ADC_SAMPLE,
    output reg [23:0] HPF_SAMPLE,
    output reg ANALOG_PATH_EN,
    output reg DMIC_PATH_EN,
    output reg [1:0] LEFT_SOURCE,
    output reg [1:0] RIGHT_SOURCE,
    output reg [3:0] LEFT_MIC_GAIN,
    output reg [3:0] RIGHT_MIC_GAIN,
    output reg LINE_AMP_ON,
    output reg [3:0] LINE_GAIN,
    output reg [1:0] SECOND_ADC_LEFT_SOURCE,
    output reg [1:0] SECOND_ADC_RIGHT_SOURCE,
    output reg [9:0] ADC_MUTE_ATT,
    output reg [9:0] SECOND_ADC_MUTE_ATT
);

    reg [7:0] power_ctrl;
    reg [7:0] input_select;
    reg [7:0] transition;
    reg [7:0] line_power;
    reg [7:0] mic_gain_setting;
    reg [7:0] line_gain_reg;
    reg [7:0] gain_ctrl;
    reg [7:0] dmic_ctrl;
    reg [7:0] dsp_mic_gain_readback;

    // three-stage synchronisers for pins
    reg [2:0] frame_sync;
    reg frame_level;
    reg [2:0] pdn_sync;
    reg pdn_level;
    wire frame_tick = (frame_sync[1] == frame_sync[2]) && frame_sync[2] && !frame_level;
    wire operating = pdn_level;

    always @(posedge CLK) begin
        if (!RST_N) begin
            // start high so a frame clock already high gives no false tick
            frame_sync <= 3'h7;
            frame_level <= 1'b1;
            pdn_sync <= 3'h0;
            pdn_level <= 1'b0;
        end else begin
            frame_sync <= {frame_sync[1:0], FRAME_CLOCK};
            pdn_sync <= {pdn_sync[1:0], POWER_DOWN_PIN_N};
            if (frame_sync[1] == frame_sync[2])
                frame_level <= frame_sync[2];
            if (pdn_sync[1] == pdn_sync[2])
                pdn_level <= pdn_sync[2];
        end
    end

    // register writes
    always @(posedge CLK) begin
        if (!RST_N) begin
            power_ctrl <= `RESET_BYTE;
            input_select <= `RESET_BYTE;
            transition <= `RESET_BYTE;
            line_power <= `RESET_BYTE;
            mic_gain_setting <= `RESET_BYTE;
            line_gain_reg <= `RESET_BYTE;
            gain_ctrl <= `RESET_BYTE;
            dmic_ctrl <= `RESET_BYTE;
        end else if (REG_WRITE) begin
            case (REG_ADDR)
                `ADDR_POWER_CTRL: power_ctrl <= REG_WDATA;
                `ADDR_INPUT_SELECT: input_select <= REG_WDATA;
                `ADDR_TRANSITION: transition <= REG_WDATA;
                `ADDR_LINE_POWER: line_power <= REG_WDATA;
                `ADDR_MIC_GAIN: mic_gain_setting <= REG_WDATA; // RL4
                `ADDR_LINE_GAIN: line_gain_reg <= REG_WDATA;
                `ADDR_GAIN_CTRL: gain_ctrl <= REG_WDATA;
                `ADDR_DMIC_CTRL: dmic_ctrl <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // register reads, one cycle after the address
    always @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            case (REG_ADDR)
                `ADDR_POWER_CTRL: REG_RDATA <= power_ctrl;
                `ADDR_INPUT_SELECT: REG_RDATA <= input_select;
                `ADDR_TRANSITION: REG_RDATA <= transition;
                `ADDR_LINE_POWER: REG_RDATA <= line_power;
                `ADDR_MIC_GAIN: REG_RDATA <= mic_gain_setting;
                `ADDR_LINE_GAIN: REG_RDATA <= line_gain_reg;
                `ADDR_GAIN_CTRL: REG_RDATA <= gain_ctrl;
                `ADDR_DSP_GAIN_READ: REG_RDATA <= dsp_mic_gain_readback; // RL12
                `ADDR_DMIC_CTRL: REG_RDATA <= dmic_ctrl;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // dsp-applied gains captured for readback
    always @(posedge CLK) begin
        if (!RST_N)
            dsp_mic_gain_readback <= 8'h00;
        else
            dsp_mic_gain_readback <= {DSP_GAIN_RIGHT, DSP_GAIN_LEFT}; // RL12
    end

    // input routing
    always @(posedge CLK) begin
        if (!RST_N) begin
            ANALOG_PATH_EN <= 1'b0;
            DMIC_PATH_EN <= 1'b0;
            LEFT_SOURCE <= `SRC_SINGLE_A;
            RIGHT_SOURCE <= `SRC_SINGLE_A;
            LINE_AMP_ON <= 1'b0;
            LINE_GAIN <= 4'h0;
            SECOND_ADC_LEFT_SOURCE <= `SECOND_ADC_SRC_NONE;
            SECOND_ADC_RIGHT_SOURCE <= `SECOND_ADC_SRC_NONE;
        end else begin
            ANALOG_PATH_EN <= power_ctrl[`BIT_ANALOG_INPUT_EN]; // RL1
            DMIC_PATH_EN <= dmic_ctrl[`BIT_DIGITAL_MIC_1_ENABLE_EN] | dmic_ctrl[`BIT_DIGITAL_MIC_2_ENABLE_EN]; // RL1
            if (input_select[`BIT_LEFT_DIFF]) // RL2
                LEFT_SOURCE <= `SRC_DIFF;
            else if (input_select[`BIT_LEFT_PIN_SEL])
                LEFT_SOURCE <= `SRC_SINGLE_B;
            else
                LEFT_SOURCE <= `SRC_SINGLE_A;
            if (input_select[`BIT_RIGHT_DIFF]) // RL3
                RIGHT_SOURCE <= `SRC_DIFF;
            else if (input_select[`BIT_RIGHT_PIN_SEL])
                RIGHT_SOURCE <= `SRC_SINGLE_B;
            else
                RIGHT_SOURCE <= `SRC_SINGLE_A;
            LINE_AMP_ON <= line_power[`BIT_LINE_AMP_POWER]; // RL13
            // unavailable code keeps the last valid gain
            if (line_gain_reg[7:4] != `LINE_GAIN_NA)
                LINE_GAIN <= line_gain_reg[7:4]; // RL14
            if (dmic_ctrl[`BIT_DIGITAL_MIC_2_ENABLE_EN]) begin // RL15
                SECOND_ADC_LEFT_SOURCE <= `SECOND_ADC_SRC_DMIC;
                SECOND_ADC_RIGHT_SOURCE <= `SECOND_ADC_SRC_DMIC;
            end else begin
                SECOND_ADC_LEFT_SOURCE <= line_power[`BIT_LINE_AMP_POWER] ?
                    `SECOND_ADC_SRC_LINE : `SECOND_ADC_SRC_NONE; // RL13
                SECOND_ADC_RIGHT_SOURCE <= `SECOND_ADC_SRC_NONE;
            end
        end
    end

    // per-channel zero-cross gain update; gain code drives amp directly
    wire [7:0] gain_applied;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gain_ch
            reg [2:0] zc_sync;
            reg zc_level;
            reg [3:0] applied;
            reg [3:0] target;
            reg pending;
            reg [9:0] zc_count;
            wire zc_pin = (ch == 0) ? ZERO_CROSS_LEFT : ZERO_CROSS_RIGHT;
            wire zc_event = (zc_sync[1] == zc_sync[2]) && (zc_sync[2] != zc_level);
            wire dsp_en = gain_ctrl[`BIT_LEFT_DSP_EN + ch];
            wire zc_en = gain_ctrl[`BIT_LEFT_ZC_EN + ch];
            wire [3:0] dsp_gain = (ch == 0) ? DSP_GAIN_LEFT : DSP_GAIN_RIGHT;
            wire [3:0] source = dsp_en ? dsp_gain : mic_gain_setting[4*ch+3:4*ch]; // RL11
            wire timeout = frame_tick && (zc_count == `ZC_TIMEOUT_SAMPLES - 1); // RL7
            always @(posedge CLK) begin
                if (!RST_N) begin
                    zc_sync <= 3'h0;
                    zc_level <= 1'b0;
                    applied <= 4'h0;
                    target <= 4'h0;
                    pending <= 1'b0;
                    zc_count <= 10'h000;
                end else begin
                    zc_sync <= {zc_sync[1:0], zc_pin};
                    if (zc_sync[1] == zc_sync[2])
                        zc_level <= zc_sync[2];
                    if (!zc_en) begin
                        applied <= source; // RL8
                        target <= source;
                        pending <= 1'b0;
                        zc_count <= 10'h000;
                    end else if (source != target) begin
                        // new value restarts the wait; same value leaves it running
                        target <= source; // RL9
                        pending <= (source != applied);
                        zc_count <= 10'h000;
                    end else if (pending) begin
                        if (zc_event || timeout) begin // RL6
                            applied <= target;
                            pending <= 1'b0;
                            zc_count <= 10'h000;
                        end else if (frame_tick) begin
                            zc_count <= zc_count + 10'h001; // RL23
                        end
                    end
                end
            end
            assign gain_applied[4*ch+3:4*ch] = applied;
        end
    endgenerate

    always @(posedge CLK) begin
        if (!RST_N) begin
            LEFT_MIC_GAIN <= 4'h0;
            RIGHT_MIC_GAIN <= 4'h0;
        end else begin
            LEFT_MIC_GAIN <= gain_applied[3:0]; // RL5
            RIGHT_MIC_GAIN <= gain_applied[7:4]; // RL5
        end
    end

    // soft mute ramps: index 0 stereo adc, index 1 second adc
    wire [19:0] att_now;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : mute_ch
            reg [9:0] att;
            reg [1:0] slow_count;
            wire mute_req = gain_ctrl[`BIT_ADC_MUTE - ch];
            wire slow = transition[`BIT_SLOW_TRANSITION];
            wire step = frame_tick && (!slow || slow_count == `SLOW_STEP_SAMPLES - 1); // RL22
            always @(posedge CLK) begin
                if (!RST_N || !operating) begin
                    att <= 10'h000; // RL20
                    slow_count <= 2'h0;
                end else begin
                    if (frame_tick)
                        slow_count <= slow_count + 2'h1; // RL23
                    if (step) begin
                        if (mute_req && att != `MUTE_RAMP_SAMPLES) // RL17
                            att <= att + 10'h001; // RL19
                        else if (!mute_req && att != 10'h000)
                            att <= att - 10'h001; // RL18
                    end
                end
            end
            assign att_now[10*ch+9:10*ch] = att;
        end
    endgenerate

    always @(posedge CLK) begin
        if (!RST_N) begin
            ADC_MUTE_ATT <= 10'h000;
            SECOND_ADC_MUTE_ATT <= 10'h000;
        end else begin
            ADC_MUTE_ATT <= att_now[9:0];
            SECOND_ADC_MUTE_ATT <= att_now[19:10];
        end
    end

    // first-order dc blocker, one update per sample
    reg signed [35:0] dc_est;
    wire signed [35:0] x_ext = {{1{ADC_SAMPLE[23]}}, ADC_SAMPLE, 11'h000};
    wire signed [35:0] err = x_ext - dc_est;
    always @(posedge CLK) begin
        if (!RST_N) begin
            dc_est <= 36'sh0;
            HPF_SAMPLE <= 24'h000000;
        end else if (frame_tick) begin
            dc_est <= dc_est + (err >>> `HPF_SHIFT); // RL16
            HPF_SAMPLE <= err[34:11]; // RL16
        end
    end

endmodule

// ---- sim/adc_input_gain_mute_ctrl_properties.sv ----
`timescale 1ns/1ns
`include "adc_front_regs.vh"
module adc_input_gain_mute_ctrl_properties (
    input wire CLK,
    input wire RST_N,
    input wire REG_WRITE,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire POWER_DOWN_PIN_N,
    input wire ANALOG_PATH_EN,
    input wire DMIC_PATH_EN,
    input wire [1:0] LEFT_SOURCE,
    input wire [1:0] RIGHT_SOURCE,
    input wire [3:0] LINE_GAIN,
    input wire [1:0] SECOND_ADC_LEFT_SOURCE,
    input wire [1:0] SECOND_ADC_RIGHT_SOURCE,
    input wire [9:0] ADC_MUTE_ATT,
    input wire [9:0] SECOND_ADC_MUTE_ATT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire wr_sel = REG_WRITE && REG_ADDR == `ADDR_INPUT_SELECT;
    wire wr_dmic = REG_WRITE && REG_ADDR == `ADDR_DMIC_CTRL;
    chk_analog_route: assert property (REG_WRITE && REG_ADDR == `ADDR_POWER_CTRL |->
        ##2 ANALOG_PATH_EN == $past(REG_WDATA[3], 2)) else $error("analog enable wrong");
    chk_dmic_route: assert property (wr_dmic |->
        ##2 DMIC_PATH_EN == ($past(REG_WDATA[7], 2) | $past(REG_WDATA[4], 2)))
        else $error("dmic enable wrong");
    chk_left_source: assert property (wr_sel |-> ##2 LEFT_SOURCE ==
        ($past(REG_WDATA[5], 2) ? 2'h2 : {1'b0, $past(REG_WDATA[4], 2)}))
        else $error("left source wrong");
    chk_right_source: assert property (wr_sel |-> ##2 RIGHT_SOURCE ==
        ($past(REG_WDATA[7], 2) ? 2'h2 : {1'b0, $past(REG_WDATA[6], 2)}))
        else $error("right source wrong");
    chk_line_gain_na: assert property (LINE_GAIN != `LINE_GAIN_NA)
        else $error("line gain took code 8");
    chk_second_adc_dmic: assert property (wr_dmic && REG_WDATA[4] |->
        ##2 SECOND_ADC_LEFT_SOURCE == 2'h2 && SECOND_ADC_RIGHT_SOURCE == 2'h2) else $error("second_adc source");
    chk_mute_bound: assert property (ADC_MUTE_ATT <= 10'h33c && SECOND_ADC_MUTE_ATT <= 10'h33c)
        else $error("mute beyond full");
    chk_mute_step: assert property ($changed(ADC_MUTE_ATT) && ADC_MUTE_ATT != 10'h000 |->
        ADC_MUTE_ATT - $past(ADC_MUTE_ATT) == 10'h001 || $past(ADC_MUTE_ATT) - ADC_MUTE_ATT == 10'h001)
        else $error("mute step not one");
    chk_pdn_clear: assert property (!POWER_DOWN_PIN_N [*8] |->
        ADC_MUTE_ATT == 10'h000 && SECOND_ADC_MUTE_ATT == 10'h000) else $error("mute kept in power-down");
endmodule
bind adc_input_gain_mute_ctrl adc_input_gain_mute_ctrl_properties i_props (
    .CLK(CLK), .RST_N(RST_N), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .POWER_DOWN_PIN_N(POWER_DOWN_PIN_N), .ANALOG_PATH_EN(ANALOG_PATH_EN),
    .DMIC_PATH_EN(DMIC_PATH_EN), .LEFT_SOURCE(LEFT_SOURCE), .RIGHT_SOURCE(RIGHT_SOURCE),
    .LINE_GAIN(LINE_GAIN), .SECOND_ADC_LEFT_SOURCE(SECOND_ADC_LEFT_SOURCE),
    .SECOND_ADC_RIGHT_SOURCE(SECOND_ADC_RIGHT_SOURCE), .ADC_MUTE_ATT(ADC_MUTE_ATT), .SECOND_ADC_MUTE_ATT(SECOND_ADC_MUTE_ATT)
);

// ---- sim/adc_input_gain_mute_ctrl_tb.sv ----
`timescale 1ns/1ns
module adc_input_gain_mute_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_write = 1'b0;
    logic pdn_n = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic frame_clock, zc_left, zc_right, an, dm, la;
    logic [3:0] dsp_l, dsp_r, lmg, rmg, lg, exp_lg;
    logic [1:0] ls, rs, a2l, a2r;
    logic [9:0] att, att2;
    logic [23:0] sample, hpf;
    logic [7:0] sh [256];
    logic [15:0] rows [13] = '{16'h0008, 16'h0910, 16'h0940, 16'h09a0, 16'h09f0, 16'h129a,
        16'h0f20, 16'h13f0, 16'h1380, 16'h1e10, 16'h1e80, 16'h1bff, 16'h55ff};
    int err_count = 0;
    int checked = 0;
    wire [22:0] seen_vec = {an, dm, ls, rs, lmg, rmg, la, lg, a2l, a2r};
    always #50 clk = ~clk;
    adc_input_gain_mute_ctrl i_dut (.CLK(clk), .RST_N(rst_n), .REG_WRITE(reg_write),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .FRAME_CLOCK(frame_clock), .POWER_DOWN_PIN_N(pdn_n), .ZERO_CROSS_LEFT(zc_left),
        .ZERO_CROSS_RIGHT(zc_right), .DSP_GAIN_LEFT(dsp_l), .DSP_GAIN_RIGHT(dsp_r),
        .ADC_SAMPLE(sample), .HPF_SAMPLE(hpf), .ANALOG_PATH_EN(an), .DMIC_PATH_EN(dm),
        .LEFT_SOURCE(ls), .RIGHT_SOURCE(rs), .LEFT_MIC_GAIN(lmg), .RIGHT_MIC_GAIN(rmg),
        .LINE_AMP_ON(la), .LINE_GAIN(lg), .SECOND_ADC_LEFT_SOURCE(a2l), .SECOND_ADC_RIGHT_SOURCE(a2r),
        .ADC_MUTE_ATT(att), .SECOND_ADC_MUTE_ATT(att2));
    analog_source_model i_model (.clk(clk), .frame_clock(frame_clock), .zc_left(zc_left),
        .zc_right(zc_right), .dsp_left(dsp_l), .dsp_right(dsp_r), .sample(sample));
    function automatic logic [22:0] expect_vec();
        return {sh[8'h00][3], sh[8'h1e][7] | sh[8'h1e][4],
            (sh[8'h09][5] ? 2'h2 : {1'b0, sh[8'h09][4]}), (sh[8'h09][7] ? 2'h2 : {1'b0, sh[8'h09][6]}),
            sh[8'h12][3:0], sh[8'h12][7:4], sh[8'h0f][5], exp_lg,
            (sh[8'h1e][4] ? 2'h2 : {1'b0, sh[8'h0f][5]}), (sh[8'h1e][4] ? 2'h2 : 2'h0)};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        if (a inside {8'h00, 8'h09, 8'h0c, 8'h0f, 8'h12, 8'h13, 8'h1a, 8'h1e}) sh[a] = d;
        if (a == 8'h13 && d[7:4] != 4'h8) exp_lg = d[7:4];
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wait_ticks(input int n);
        int t0;
        t0 = i_model.ticks;
        for (int k = 0; k < n * 16 && i_model.ticks < t0 + n; k++) @(posedge clk);
        if (i_model.ticks < t0 + n) begin
            err_count++;
            wrap_up();
        end
        #1;
    endtask
    initial begin
        foreach (sh[i]) sh[i] = 8'h00;
        exp_lg = 4'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check("reset_vec", seen_vec, 0);
        check("reset_att", {att, att2}, 0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][15:8], rows[i][7:0]);
            check("route_vec", seen_vec, expect_vec());
            if (rows[i][15:8] != 8'h1b) check("readback", reg_rdata, sh[rows[i][15:8]]);
        end
        $display("test rows done");
        wr(8'h1a, 8'h01);
        wr(8'h12, 8'h35);
        check("gain_r_now", rmg, 4'h3);
        check("gain_l_hold", lmg, 4'ha);
        i_model.cross_left();
        repeat (8) @(posedge clk);
        #1;
        check("gain_l_cross", lmg, 4'h5);
        wr(8'h12, 8'h37);
        wait_ticks(400);
        wr(8'h12, 8'h37);
        wait_ticks(360);
        check("gain_l_wait", lmg, 4'h5);
        wait_ticks(16);
        check("gain_l_timeout", lmg, 4'h7);
        wr(8'h1a, 8'h02);
        wr(8'h12, 8'h95);
        check("gain_l_now", lmg, 4'h5);
        check("gain_r_hold", rmg, 4'h3);
        i_model.cross_right();
        repeat (8) @(posedge clk);
        #1;
        check("gain_r_cross", rmg, 4'h9);
        $display("test zero_cross done");
        wr(8'h1a, 8'h0c);
        check("dsp_gain", {lmg, rmg}, 8'hc6);
        wr(8'h1b, 8'h00);
        check("dsp_readback", reg_rdata, 8'h6c);
        $display("test dsp done");
        wr(8'h1a, 8'h80);
        wait_ticks(414);
        check("mute_half", att >= 404 && att <= 424, 1);
        wait_ticks(430);
        check("mute_full", att, 828);
        wr(8'h09, 8'h10);
        check("switch_muted", {ls, att}, {2'h1, 10'h33c});
        wr(8'h1a, 8'h00);
        wait_ticks(840);
        check("unmute", att, 0);
        wr(8'h1a, 8'h80);
        wait_ticks(100);
        wr(8'h1a, 8'h00);
        wait_ticks(50);
        check("cancel_mid", att >= 40 && att <= 62, 1);
        wait_ticks(70);
        check("cancel_end", att, 0);
        wr(8'h0c, 8'h20);
        wr(8'h1a, 8'h40);
        wait_ticks(828);
        check("slow_ramp", att2 >= 200 && att2 <= 214, 1);
        check("other_idle", att, 0);
        @(posedge clk);
        pdn_n <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check("pdn_clear", att2, 0);
        @(posedge clk);
        pdn_n <= 1'b1;
        #1;
        check("hpf", $signed(hpf) > 0 && hpf < sample, 1);
        $display("test mute done");
        wrap_up();
    end
endmodule

// ---- sim/analog_source_model.sv ----
`timescale 1ns/1ns
module analog_source_model (
    input wire logic clk,
    output logic frame_clock,
    output logic zc_left,
    output logic zc_right,
    output logic [3:0] dsp_left,
    output logic [3:0] dsp_right,
    output logic [23:0] sample
);
    int ticks = 0;
    logic [2:0] phase = 3'h0;
    // frame clock eight system clocks long so long counts stay short
    assign frame_clock = ~phase[2];
    assign dsp_left = 4'hc;
    assign dsp_right = 4'h6;
    assign sample = 24'h100000;
    initial begin
        zc_left = 1'b0;
        zc_right = 1'b0;
    end
    always @(posedge clk) begin
        phase <= phase + 3'h1;
    end
    always @(posedge frame_clock) begin
        ticks <= ticks + 1;
    end
    task cross_left();
        @(posedge clk);
        zc_left <= ~zc_left;
    endtask
    task cross_right();
        @(posedge clk);
        zc_right <= ~zc_right;
    endtask
endmodule
